// file: rtl/lhp_map.vh
// Constants for the display host port: command codes, field positions, timing
`ifndef LHP_MAP_VH
`define LHP_MAP_VH

// Synchronised pin vector layout
`define LHP_SYNC_W 10
`define LHP_SQ_STB 9
`define LHP_SQ_CS 8
`define LHP_SQ_CD 7
`define LHP_SQ_NIB_HI 6
`define LHP_SQ_NIB_LO 3
`define LHP_SQ_ID_HI 2
`define LHP_SQ_ID_LO 1
`define LHP_SQ_SYNC 0

// Nibble bus pins that double as straps and serial lines
`define LHP_PIN_SI 0
`define LHP_PIN_PS 1
`define LHP_PIN_CAE 2
`define LHP_PIN_SO 3

// Cycles after reset release before the straps are taken
`define LHP_STARTUP_CNT 3'h4

// Serial bit count of one byte, minus one
`define LHP_LAST_BIT 3'h7

// Mode-set command: bits 7..3 opcode, bit 2 master, bit 1 shared as columns,
// bit 0 rows carry the upper half
`define LHP_MSET_OP 5'h02
`define LHP_MSET_MASTER 2
`define LHP_MSET_COLS 1
`define LHP_MSET_ROWHI 0

// Chip address command: bits 7..2 opcode, bits 1..0 chip address
`define LHP_CADR_OP 6'h3f

// Reset values
`define LHP_RST_BYTE 8'h00
`define LHP_RST_NIB 4'h0

// Buffer entry: command flag above the byte
`define LHP_ENTRY_W 9

`endif

// file: rtl/lhp_sync.v
// Three-stage pin synchroniser; an output bit moves once stages two and three agree
`timescale 1ns/1ps
module lhp_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // Pins and clean levels
   input wire [W-1:0] pin_i,
   output wire [W-1:0] level_o
);
   reg [W-1:0] st1_r;
   reg [W-1:0] st2_r;
   reg [W-1:0] st3_r;
   reg [W-1:0] level_r;
   integer i;

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st1_r <= {W{1'b0}};
         st2_r <= {W{1'b0}};
         st3_r <= {W{1'b0}};
         level_r <= {W{1'b0}};
      end else begin
         st1_r <= pin_i;
         st2_r <= st1_r;
         st3_r <= st2_r;
         for (i = 0; i < W; i = i + 1) begin
            if (st2_r[i] == st3_r[i]) begin
               level_r[i] <= st3_r[i];
            end
         end
      end
   end

   assign level_o = level_r;
endmodule

// file: rtl/lhp_buf.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module lhp_buf #(
   parameter W = 9
) (
   // Clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // Fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   // Drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] mem_r [0:1];
   reg wr_ptr_r;
   reg rd_ptr_r;
   reg [1:0] count_r;
   wire push;
   wire pop;

   assign in_ready_o = (count_r != 2'h2);
   assign out_valid_o = (count_r != 2'h0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mem_r[0] <= {W{1'b0}};
         mem_r[1] <= {W{1'b0}};
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         if (push & ~pop) begin
            count_r <= count_r + 2'h1;
         end else if (pop & ~push) begin
            count_r <= count_r - 2'h1;
         end
      end
   end
endmodule

// file: rtl/lhp_port.v
// Host port of the display controller: nibble or serial bus, busy, chip address, sync
`timescale 1ns/1ps
`include "lhp_map.vh"
module lhp_port (
   // Clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // Host pins
   input wire cs_n_i,
   input wire strobe_n_i,
   input wire cmd_data_i,
   input wire [3:0] nibble_bus_i,
   output wire [3:0] nibble_bus_o,
   output wire [3:0] nibble_bus_oe_n_o,
   input wire chip_id_bit0_i,
   input wire chip_id_bit1_i,
   output wire busy_n_o,
   output wire busy_oe_n_o,
   // Frame sync pin
   input wire sync_i,
   output wire sync_o,
   output wire sync_oe_n_o,
   // Received bytes towards the command decoder and memory
   output wire rx_valid_o,
   input wire rx_ready_i,
   output wire rx_cmd_o,
   output wire [7:0] rx_data_o,
   input wire proc_done_i,
   // Read data from display memory
   input wire tx_valid_i,
   output wire tx_ready_o,
   input wire [7:0] tx_data_i,
   // Data processing mode control
   input wire set_read_i,
   input wire set_write_i,
   output wire read_mode_o,
   // Standby control
   input wire standby_req_i,
   output wire standby_o,
   // Drive timing
   input wire frame_last_i,
   output wire frame_align_o,
   output wire alt_phase_o,
   // Configuration seen by the drivers
   output wire parallel_mode_o,
   output wire sync_master_o,
   output wire shared_as_cols_o,
   output wire rows_upper_o
);
   wire [`LHP_SYNC_W-1:0] sq;
   wire s_stb;
   wire s_cs;
   wire s_cd;
   wire [3:0] s_nib;
   wire [1:0] s_id;
   wire s_sync;

   reg [2:0] up_cnt_r;
   reg up_done_r;
   reg par_mode_r;
   reg cae_r;
   reg addr_hit_r;
   reg stb_d_r;
   reg sync_d_r;
   reg [7:0] sh_r;
   reg [2:0] bit_cnt_r;
   reg nib_ph_r;
   reg busy_r;
   reg int_done_r;
   reg pend_r;
   reg [`LHP_ENTRY_W-1:0] pend_data_r;
   reg rd_mode_r;
   reg out_full_r;
   reg [3:0] nib_out_r;
   reg master_r;
   reg cols_r;
   reg rowhi_r;
   reg sync_out_r;
   reg align_r;
   reg alt_r;
   reg standby_r;

   wire cs_low;
   wire addr_fn;
   wire addr_ok;
   wire sel;
   wire rise;
   wire fall;
   wire wr_edge;
   wire rd_edge;
   wire lat_go;
   wire [7:0] lat_val;
   wire lat_cmd;
   wire is_cadr;
   wire is_mset;
   wire accepted;
   wire buf_in_ready;
   wire tx_load;
   wire rd_empty;
   wire byte_end;
   reg busy_nxt;

   // Chip address compare of the host-supplied address
   function cadr_match;
      input [1:0] host_addr;
      input [1:0] chip_id;
      begin
         cadr_match = (host_addr == chip_id);
      end
   endfunction

   // All host pins pass the three-stage synchroniser
   lhp_sync #(
      .W(`LHP_SYNC_W)
   ) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i({strobe_n_i, cs_n_i, cmd_data_i, nibble_bus_i,
         chip_id_bit1_i, chip_id_bit0_i, sync_i}),
      .level_o(sq)
   );

   assign s_stb = sq[`LHP_SQ_STB];
   assign s_cs = sq[`LHP_SQ_CS];
   assign s_cd = sq[`LHP_SQ_CD];
   assign s_nib = sq[`LHP_SQ_NIB_HI:`LHP_SQ_NIB_LO];
   assign s_id = sq[`LHP_SQ_ID_HI:`LHP_SQ_ID_LO];
   assign s_sync = sq[`LHP_SQ_SYNC];

   // Selection and chip address
   assign cs_low = ~s_cs & up_done_r;
   assign addr_fn = par_mode_r | cae_r;
   assign addr_ok = ~addr_fn | addr_hit_r;
   assign sel = cs_low & addr_ok;

   assign rise = s_stb & ~stb_d_r;
   assign fall = ~s_stb & stb_d_r;
   assign wr_edge = cs_low & ~rd_mode_r & ~busy_r & ~pend_r & rise;
   assign rd_edge = sel & rd_mode_r & out_full_r & fall;

   // Byte completion: second strobe or eighth serial clock
   assign byte_end = par_mode_r ? nib_ph_r : (bit_cnt_r == `LHP_LAST_BIT);
   assign lat_go = wr_edge & byte_end;
   assign lat_val = par_mode_r ? {sh_r[7:4], s_nib} : {sh_r[6:0], s_nib[`LHP_PIN_SI]};
   assign lat_cmd = s_cd;
   assign is_cadr = lat_cmd & (lat_val[7:2] == `LHP_CADR_OP);
   assign is_mset = lat_cmd & (lat_val[7:3] == `LHP_MSET_OP);
   // Chip address command reaches every chip on the shared select
   assign accepted = addr_ok | (is_cadr & addr_fn);

   assign tx_load = tx_valid_i & ~out_full_r;
   assign rd_empty = rd_edge & byte_end;

   // Busy: set at latch or when a read byte is used up, cleared when done
   always @* begin
      busy_nxt = busy_r;
      if (lat_go & accepted) begin
         busy_nxt = 1'b1;
      end else if (rd_empty) begin
         busy_nxt = 1'b1;
      end else if (int_done_r | proc_done_i | (rd_mode_r & tx_load)) begin
         busy_nxt = 1'b0;
      end
   end

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         up_cnt_r <= 3'h0;
         up_done_r <= 1'b0;
         par_mode_r <= 1'b0;
         cae_r <= 1'b0;
         addr_hit_r <= 1'b0;
         stb_d_r <= 1'b0;
         sync_d_r <= 1'b0;
         sh_r <= `LHP_RST_BYTE;
         bit_cnt_r <= 3'h0;
         nib_ph_r <= 1'b0;
         busy_r <= 1'b0;
         int_done_r <= 1'b0;
         pend_r <= 1'b0;
         pend_data_r <= {`LHP_ENTRY_W{1'b0}};
         rd_mode_r <= 1'b0;
         out_full_r <= 1'b0;
         nib_out_r <= `LHP_RST_NIB;
         master_r <= 1'b0;
         cols_r <= 1'b0;
         rowhi_r <= 1'b0;
         sync_out_r <= 1'b0;
         align_r <= 1'b0;
         alt_r <= 1'b0;
         standby_r <= 1'b0;
      end else begin
         stb_d_r <= s_stb;
         sync_d_r <= s_sync;
         busy_r <= busy_nxt;
         int_done_r <= lat_go & accepted & (is_cadr | is_mset);

         // Straps taken once the synchroniser has settled after release
         if (~up_done_r) begin
            up_cnt_r <= up_cnt_r + 3'h1;
            if (up_cnt_r == `LHP_STARTUP_CNT) begin
               up_done_r <= 1'b1;
               par_mode_r <= s_nib[`LHP_PIN_PS];
               cae_r <= ~s_nib[`LHP_PIN_PS] & s_nib[`LHP_PIN_CAE];
            end
         end

         // Data processing mode from the command decoder
         if (set_read_i) begin
            rd_mode_r <= 1'b1;
         end else if (set_write_i) begin
            rd_mode_r <= 1'b0;
         end

         // Counters restart whenever the select goes away
         if (~cs_low) begin
            bit_cnt_r <= 3'h0;
            nib_ph_r <= 1'b0;
         end else if (wr_edge) begin
            if (par_mode_r) begin
               sh_r <= nib_ph_r ? lat_val : {s_nib, sh_r[3:0]};
               nib_ph_r <= ~nib_ph_r;
            end else begin
               sh_r <= lat_val;
               bit_cnt_r <= bit_cnt_r + 3'h1;
            end
         end else if (rd_edge) begin
            if (par_mode_r) begin
               nib_out_r <= nib_ph_r ? sh_r[3:0] : sh_r[7:4];
               nib_ph_r <= ~nib_ph_r;
            end else begin
               nib_out_r[`LHP_PIN_SO] <= sh_r[7];
               sh_r <= {sh_r[6:0], 1'b0};
               bit_cnt_r <= bit_cnt_r + 3'h1;
            end
         end
         if (rd_mode_r & tx_load) begin
            sh_r <= tx_data_i;
         end

         // Read holding register: reloaded after each byte goes out
         if (~rd_mode_r) begin
            out_full_r <= 1'b0;
         end else if (rd_empty) begin
            out_full_r <= 1'b0;
         end else if (tx_load & ~rd_edge) begin
            out_full_r <= 1'b1;
         end

         // Latched byte handling
         if (lat_go) begin
            if (is_cadr & addr_fn) begin
               addr_hit_r <= cadr_match(lat_val[1:0], s_id);
            end else if (is_mset & addr_ok) begin
               master_r <= lat_val[`LHP_MSET_MASTER];
               cols_r <= lat_val[`LHP_MSET_COLS];
               rowhi_r <= lat_val[`LHP_MSET_ROWHI];
            end else if (addr_ok) begin
               pend_r <= 1'b1;
               pend_data_r <= {lat_cmd, lat_val};
            end
         end else if (pend_r & buf_in_ready) begin
            pend_r <= 1'b0;
         end

         // Frame sync: master drives, slave follows
         sync_out_r <= master_r & frame_last_i;
         align_r <= ~master_r & s_sync & ~sync_d_r;
         if (master_r ? frame_last_i : (s_sync & ~sync_d_r)) begin
            alt_r <= ~alt_r;
         end

         if (standby_req_i) begin
            standby_r <= 1'b1;
         end
      end
   end

   // Stall-safe buffer towards the decoder
   lhp_buf #(
      .W(`LHP_ENTRY_W)
   ) u_buf (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(pend_r),
      .in_ready_o(buf_in_ready),
      .in_data_i(pend_data_r),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o({rx_cmd_o, rx_data_o})
   );

   // Pin drive: nibble and busy floated unless selected, sync driven whenever master
   assign nibble_bus_o = nib_out_r;
   assign nibble_bus_oe_n_o = (sel & rd_mode_r) ? (par_mode_r ? 4'h0 : 4'h7)
      : 4'hf;
   assign busy_n_o = ~busy_r;
   assign busy_oe_n_o = ~sel;
   assign sync_o = sync_out_r;
   assign sync_oe_n_o = ~master_r;

   assign tx_ready_o = rd_mode_r & ~out_full_r;
   assign read_mode_o = rd_mode_r;
   assign standby_o = standby_r;
   assign frame_align_o = align_r;
   assign alt_phase_o = alt_r;
   assign parallel_mode_o = par_mode_r;
   assign sync_master_o = master_r;
   assign shared_as_cols_o = cols_r;
   assign rows_upper_o = rowhi_r;
endmodule

// file: rtl/lhp_port_end.v
// (unused)

// file: dv/lhp_port_props.sv
// Checker on the display host port pins
`timescale 1ns/1ps
module lhp_port_props (
   // Clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // Host side
   input wire cs_n_i,
   input wire strobe_n_i,
   input wire [3:0] nibble_bus_oe_n_o,
   input wire busy_n_o,
   input wire busy_oe_n_o,
   input wire proc_done_i,
   // Sync and configuration
   input wire frame_last_i,
   input wire sync_o,
   input wire sync_oe_n_o,
   input wire sync_master_o,
   input wire parallel_mode_o,
   // Received bytes
   input wire rx_valid_o,
   input wire rx_ready_i,
   input wire [7:0] rx_data_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_cs_float: assert property (cs_n_i [*7] |-> nibble_bus_oe_n_o == 4'hf && busy_oe_n_o)
      else $error("driving while deselected");
   a_desel_idle: assert property (cs_n_i [*8] |-> !$fell(busy_n_o))
      else $error("accepted while deselected");
   a_busy_free: assert property ($stable(strobe_n_i) [*8] ##0 proc_done_i |=> busy_n_o)
      else $error("busy not released");
   a_sync_pulse: assert property (sync_master_o && frame_last_i |=> sync_o)
      else $error("no frame pulse");
   a_sync_dir: assert property (sync_oe_n_o == !sync_master_o)
      else $error("sync direction wrong");
   a_rx_stall: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("byte lost in stall");
   a_par_oe: assert property (parallel_mode_o |-> nibble_bus_oe_n_o inside {4'h0, 4'hf})
      else $error("partial nibble drive");
   a_serial_oe: assert property (!parallel_mode_o |-> nibble_bus_oe_n_o[2:0] == 3'h7)
      else $error("serial drives input lines");
   c_rx: cover property (rx_valid_o && rx_ready_i);
   c_busy: cover property ($fell(busy_n_o));
   c_par_read: cover property (nibble_bus_oe_n_o == 4'h0);
endmodule

// file: dv/lhp_host_model.sv
// Host processor model on the nibble or serial bus
`timescale 1ns/1ps
module lhp_host_model (
   // Clock
   input wire clk_i,
   // Device side of the shared lines
   input wire [3:0] nib_oe_n_i,
   input wire [3:0] nib_drv_i,
   // Host pins
   output logic cs_n_o = 1'b1,
   output logic strobe_n_o = 1'b1,
   output logic cmd_data_o = 1'b0,
   output wire [3:0] nib_o
);
   logic ser = 1'b0;
   logic [3:0] hv = 4'h0;
   assign nib_o = (~nib_oe_n_i & nib_drv_i) | (nib_oe_n_i & hv);
   // One byte; on reads the host side toggles so a released line never looks driven
   task automatic xfer(input logic rd, input logic c, input logic [7:0] wb,
         output logic [7:0] rb);
      int i;
      logic [3:0] s;
      begin
         rb = 8'h00;
         @(negedge clk_i);
         cmd_data_o = c;
         repeat (8) @(negedge clk_i);
         for (i = 0; i < (ser ? 8 : 2); i++) begin
            hv = rd ? ~hv : ser ? {3'h0, wb[7 - i]} : (i == 0 ? wb[7:4] : wb[3:0]);
            strobe_n_o = 1'b0;
            repeat (8) @(negedge clk_i);
            s = nib_o;
            strobe_n_o = 1'b1;
            repeat (8) @(negedge clk_i);
            rb = ser ? {rb[6:0], s[3]} : {rb[3:0], s};
         end
      end
   endtask
endmodule

// file: dv/lhp_port_tb_top.sv
// Self-checking bench for the display host port
`timescale 1ns/1ps
module lhp_port_tb_top;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic chip_id_bit0_i = 1'b0;
   logic chip_id_bit1_i = 1'b0;
   logic rx_ready_i = 1'b0;
   logic proc_done_i = 1'b0;
   logic tx_valid_i = 1'b0;
   logic set_read_i = 1'b0;
   logic set_write_i = 1'b0;
   logic standby_req_i = 1'b0;
   logic frame_last_i = 1'b0;
   logic sync_i = 1'b0;
   logic [7:0] tx_data_i = 8'h00;
   logic [7:0] rd_byte;
   wire [7:0] rx_data_o;
   wire [3:0] nibble_bus_i, nibble_bus_o, nibble_bus_oe_n_o;
   wire cs_n_i, strobe_n_i, cmd_data_i, busy_n_o, busy_oe_n_o, sync_o, sync_oe_n_o;
   wire rx_valid_o, rx_cmd_o, tx_ready_o, read_mode_o, standby_o, parallel_mode_o;
   wire sync_master_o, shared_as_cols_o, rows_upper_o, frame_align_o, alt_phase_o;
   int n_errors = 0;
   int checks_done = 0;
   always #12.5 clk_i = ~clk_i;
   lhp_port lhp_port_inst (
      .clk_i, .sys_rst_i, .cs_n_i, .strobe_n_i, .cmd_data_i, .nibble_bus_i, .nibble_bus_o,
      .nibble_bus_oe_n_o, .chip_id_bit0_i, .chip_id_bit1_i, .busy_n_o, .busy_oe_n_o,
      .sync_i, .sync_o, .sync_oe_n_o, .rx_valid_o, .rx_ready_i, .rx_cmd_o, .rx_data_o,
      .proc_done_i, .tx_valid_i, .tx_ready_o, .tx_data_i, .set_read_i, .set_write_i,
      .read_mode_o, .standby_req_i, .standby_o, .frame_last_i, .frame_align_o,
      .alt_phase_o, .parallel_mode_o, .sync_master_o, .shared_as_cols_o, .rows_upper_o
   );
   lhp_host_model lhp_host_model_inst (
      .clk_i, .nib_oe_n_i(nibble_bus_oe_n_o), .nib_drv_i(nibble_bus_o), .cs_n_o(cs_n_i),
      .strobe_n_o(strobe_n_i), .cmd_data_o(cmd_data_i), .nib_o(nibble_bus_i)
   );
   task automatic print_verdict;
      begin
         if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      begin
         checks_done++;
         if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task automatic pulse(ref logic s);
      begin
         @(negedge clk_i);
         s = 1'b1;
         @(negedge clk_i);
         s = 1'b0;
      end
   endtask
   task automatic do_rst(input logic ps, input logic cae);
      begin
         lhp_host_model_inst.cs_n_o = 1'b1;
         lhp_host_model_inst.ser = !ps;
         lhp_host_model_inst.hv = {1'b0, cae, ps, 1'b0};
         sys_rst_i = 1'b1;
         repeat (5) @(negedge clk_i);
         sys_rst_i = 1'b0;
         repeat (16) @(negedge clk_i);
         cmp(parallel_mode_o, ps);
         cmp(read_mode_o, 1'b0);
         cmp(standby_o, 1'b0);
         cmp(busy_oe_n_o, 1'b1);
         lhp_host_model_inst.cs_n_o = 1'b0;
         repeat (8) @(negedge clk_i);
      end
   endtask
   task automatic snd(input logic c, input logic [7:0] b);
      int k;
      begin
         for (k = 0; busy_n_o !== 1'b1; k++) begin
            if (k == 400) begin
               n_errors++;
               print_verdict();
            end
            @(negedge clk_i);
         end
         lhp_host_model_inst.xfer(1'b0, c, b, rd_byte);
         repeat (6) @(negedge clk_i);
      end
   endtask
   task automatic t_match;
      begin
         chip_id_bit1_i = 1'b1;
         snd(1'b1, 8'hfd);
         snd(1'b0, 8'h5a);
         cmp(rx_valid_o, 1'b0);
         cmp(busy_oe_n_o, 1'b1);
         pulse(proc_done_i);
         snd(1'b1, 8'hfe);
         cmp(busy_oe_n_o, 1'b0);
      end
   endtask
   task automatic t_mset;
      logic [7:0] m;
      logic [7:0] n;
      logic a;
      begin
         for (int i = 0; i < 2; i++) begin
            m = i ? 8'h15 : 8'h12;
            snd(1'b1, m);
            cmp({sync_master_o, shared_as_cols_o, rows_upper_o}, m[2:0]);
            cmp(sync_oe_n_o, !m[2]);
            if (!m[2]) begin
               a = alt_phase_o;
               n = 8'h00;
               sync_i = 1'b1;
               repeat (8) begin
                  @(negedge clk_i);
                  n += frame_align_o;
               end
               sync_i = 1'b0;
               cmp(n, 8'h01);
               cmp(alt_phase_o, !a);
            end
         end
         a = alt_phase_o;
         pulse(frame_last_i);
         cmp(sync_o, 1'b1);
         cmp(alt_phase_o, !a);
      end
   endtask
   task automatic t_write;
      begin
         snd(1'b0, 8'ha5);
         cmp(rx_data_o, 8'ha5);
         cmp(rx_cmd_o, 1'b0);
         repeat (20) @(negedge clk_i);
         cmp(busy_n_o, 1'b0);
         pulse(proc_done_i);
         cmp(busy_n_o, 1'b1);
         snd(1'b1, 8'h40);
         pulse(proc_done_i);
         cmp(rx_data_o, 8'ha5);
         rx_ready_i = 1'b1;
         @(negedge clk_i);
         rx_ready_i = 1'b0;
         cmp(rx_data_o, 8'h40);
         cmp(rx_cmd_o, 1'b1);
         pulse(rx_ready_i);
         cmp(rx_valid_o, 1'b0);
      end
   endtask
   task automatic t_read;
      begin
         pulse(set_read_i);
         cmp(read_mode_o, 1'b1);
         tx_data_i = lhp_host_model_inst.ser ? 8'hc3 : 8'h3c;
         pulse(tx_valid_i);
         cmp(tx_ready_o, 1'b0);
         lhp_host_model_inst.xfer(1'b1, 1'b0, 8'h00, rd_byte);
         cmp(rd_byte, tx_data_i);
         cmp(tx_ready_o, 1'b1);
         cmp(busy_n_o, 1'b0);
         pulse(set_write_i);
      end
   endtask
   task automatic t_serial;
      begin
         pulse(standby_req_i);
         cmp(standby_o, 1'b1);
         chip_id_bit1_i = 1'b0;
         do_rst(1'b0, 1'b0);
         snd(1'b0, 8'h96);
         cmp(rx_data_o, 8'h96);
         pulse(proc_done_i);
         pulse(rx_ready_i);
         t_read();
         do_rst(1'b0, 1'b1);
         snd(1'b0, 8'h77);
         cmp(rx_valid_o, 1'b0);
         snd(1'b1, 8'hfc);
         snd(1'b0, 8'h77);
         cmp(rx_data_o, 8'h77);
      end
   endtask
   initial begin
      do_rst(1'b1, 1'b0);
      t_match();
      t_mset();
      t_write();
      t_read();
      t_serial();
      print_verdict();
   end
endmodule
bind lhp_port lhp_port_props lhp_port_props_inst (
   .clk_i, .sys_rst_i, .cs_n_i, .strobe_n_i, .nibble_bus_oe_n_o, .busy_n_o, .busy_oe_n_o,
   .proc_done_i, .frame_last_i, .sync_o, .sync_oe_n_o, .sync_master_o, .parallel_mode_o,
   .rx_valid_o, .rx_ready_i, .rx_data_o
);
